// File: rtl/ccp_defs.svh
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

// ********************
// three-level pin codes
// ********************
`define CCP_LVL_LOW            2'h0
`define CCP_LVL_MID            2'h1
`define CCP_LVL_HIGH           2'h2

// ********************
// address byte and transfer types
// ********************
`define CCP_ADDR_MSB           7
`define CCP_ADDR_LSB           2
`define CCP_TYPE_DATA          2'h0
`define CCP_TYPE_STATUS        2'h2
`define CCP_SEL_MSB            7
`define CCP_SEL_LSB            6

// ********************
// clock ratio and format codes
// ********************
`define CCP_SC_384             2'h1
`define CCP_SC_256             2'h2
`define CCP_IF_I2S             3'h0
`define CCP_IF_MSB             3'h4
`define CCP_IF_LSB16_MSBOUT    3'h5
`define CCP_IF_LSB20_MSBOUT    3'h7
`define CCP_DE_NONE            2'h0
`define CCP_DE_44K1            2'h2

// ********************
// reset values of the control fields
// ********************
`define CCP_RST_SC             2'h0
`define CCP_RST_IF             3'h0
`define CCP_RST_VOLUME         6'h00
`define CCP_RST_POWER          2'h0

// ********************
// overload detector
// ********************
// -1.16 dB of 2^19-1 full scale
`define CCP_OVL_THRESHOLD      458650
`define CCP_OVL_HOLD_SAMPLES   512

// ********************
// host register offsets and fields
// ********************
`define CCP_REG_SEND_ADDR      8'h00
`define CCP_REG_SEND_DATA      8'h01
`define CCP_REG_PINS           8'h02
`define CCP_REG_STATUS         8'h03
`define CCP_PINS_MSA           0
`define CCP_PINS_MSB_B         1
`define CCP_PINS_FMT_A         2
`define CCP_PINS_DEEMPH_LSB    3
`define CCP_PINS_RATIO         5
`define CCP_PINS_ADC_LSB       6
`define CCP_PINS_FMT_B         8
`define CCP_PINS_WIDTH         9
`define CCP_RST_PINS           9'h000
`define CCP_STAT_BUSY          0
`define CCP_STAT_OVL           1

// ********************
// link timing
// ********************
`define CCP_CLK_PERIOD_NS      5
`define CCP_LINK_HALF_NS       200

`endif

// File: rtl/ccp_pkg.sv
package ccp_pkg;

  typedef enum logic [1:0] {
    CCP_SERIAL,
    CCP_STATIC,
    CCP_TEST
  } ccp_mode_type;

  typedef enum logic [2:0] {
    CCP_H_IDLE,
    CCP_H_SETUP,
    CCP_H_LOW,
    CCP_H_HIGH,
    CCP_H_HOLD
  } ccp_hstate_type;

endpackage

// File: rtl/ccp_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ccp_if;
  // ********************
  // strap and multipurpose pins
  // ********************
  logic       mode_select_a;
  logic       mode_select_b;
  logic       format_pin_a_or_overload_out;
  logic       ovl_out;
  logic       ovl_oe_n;
  logic       host_fmt_a;
  logic [1:0] deemph_mute_pin_or_link_mode;
  logic       clock_ratio_pin_or_link_clock;
  logic [1:0] adc_level_pin_or_link_data;
  logic       format_pin_b_or_gain_select;

  // device drives the shared pin only while its enable is low
  assign format_pin_a_or_overload_out = !ovl_oe_n ? ovl_out : host_fmt_a;

  modport device (
    input  mode_select_a, mode_select_b, format_pin_a_or_overload_out,
    input  deemph_mute_pin_or_link_mode, clock_ratio_pin_or_link_clock,
    input  adc_level_pin_or_link_data, format_pin_b_or_gain_select,
    output ovl_out, ovl_oe_n
  );

  modport host (
    output mode_select_a, mode_select_b, host_fmt_a,
    output deemph_mute_pin_or_link_mode, clock_ratio_pin_or_link_clock,
    output adc_level_pin_or_link_data, format_pin_b_or_gain_select,
    input  format_pin_a_or_overload_out
  );
endinterface

`default_nettype wire

// File: rtl/ccp_sync.sv
`timescale 1ns/10ps
`default_nettype none

module ccp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  // ********************
  // two-stage synchroniser per bit
  // ********************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q <= 1'b0;
          q[i]   <= 1'b0;
        end else if (ce) begin
          meta_q <= d[i];
          q[i]   <= meta_q;
        end
      end
    end
  endgenerate

endmodule // ccp_sync

`default_nettype wire

// File: rtl/ccp_device.sv
// Summary of operation
// - both mode pins high selects static mode
// - both mode pins low selects serial mode
// - static clock pin: low 256, high 384
// - three-level pin: none, 44.1k de-emphasis, mute
// - two format pins pick input format
// - three-level pin: power-down, 6 dB, 0 dB
// - serial mode reassigns five multipurpose pins
// - flag samples beyond -1.16 dB either channel
// - hold overload flag 512 samples, retriggerable
// - serial gain pin: low 0 dB, high 6 dB
// - link bytes travel least significant bit first
// - address phase: mode low, eight clock pulses
// - address bits 7..2 matched against device address
// - address bits 1..0 choose data or status group
// - foreign address deselects, later bytes ignored
// - selection holds until next address phase
// - controller keeps link rate at most 64 fs
// - byte committed only after eighth bit
// - link is write-only toward the device
// - bits 7..6 pick register, 5..0 value
// - status byte: ratio, format, dc filter
// - data group: volume, tone, de-emphasis, power
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ccp_defs.svh"

module ccp_device import ccp_pkg::*; #(
  parameter logic [5:0] DEV_ADDR = 6'h2a,  // arbitrary value
  parameter int         SW       = 20,
  parameter int         THRESH   = `CCP_OVL_THRESHOLD,
  parameter int         HOLD     = `CCP_OVL_HOLD_SAMPLES
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  // pins
  ccp_if.device              pins,
  // adc output samples
  input  wire logic          sample_valid,
  input  wire logic [SW-1:0] left_sample,
  input  wire logic [SW-1:0] right_sample,
  // control state
  output ccp_mode_type       ctl_mode_q,
  output var  logic          selected_q,
  output var  logic [1:0]    xfer_type_q,
  output var  logic [1:0]    clock_ratio_field_q,
  output var  logic [2:0]    input_format_q,
  output var  logic          dc_filter_q,
  output var  logic [5:0]    volume_field_q,
  output var  logic [3:0]    bass_boost_q,
  output var  logic [1:0]    treble_q,
  output var  logic [1:0]    deemphasis_q,
  output var  logic          mute_q,
  output var  logic [1:0]    filter_mode_q,
  output var  logic [1:0]    power_control_field_q,
  output var  logic          adc_powerdown_q,
  output var  logic          adc_gain_6db_q,
  output var  logic          overload_q
);

  // ********************
  // pin synchronisation
  // ********************
  // link clock enters inverted so the reset level matches its idle high
  logic [8:0] syn;
  logic       ms_a, ms_b, p_fmt_a, p_ratio, p_ratio_n, p_fmt_b;
  logic [1:0] p_deemph, p_adc;

  ccp_sync #(.WIDTH(9)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       ({pins.mode_select_b, pins.mode_select_a,
               pins.format_pin_a_or_overload_out,
               pins.deemph_mute_pin_or_link_mode,
               !pins.clock_ratio_pin_or_link_clock,
               pins.adc_level_pin_or_link_data,
               pins.format_pin_b_or_gain_select}),
    .q       (syn)
  );

  assign {ms_b, ms_a, p_fmt_a, p_deemph, p_ratio_n, p_adc, p_fmt_b} = syn;
  assign p_ratio = !p_ratio_n;

  // ********************
  // mode decode
  // ********************
  ccp_mode_type mode_d;
  logic         serial, static_m;

  always_comb begin
    if (ms_a && ms_b) begin
      mode_d = CCP_STATIC;
    end else if (!ms_a && !ms_b) begin
      mode_d = CCP_SERIAL;
    end else begin
      mode_d = CCP_TEST;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_mode_q <= CCP_TEST;
    end else if (ce) begin
      ctl_mode_q <= mode_d;
    end
  end

  assign serial   = (ctl_mode_q == CCP_SERIAL);
  assign static_m = (ctl_mode_q == CCP_STATIC);

  // ********************
  // link receiver
  // ********************
  // pins reassigned to link roles in serial mode
  logic       lclk, lmode, ldata, lclk_prev_q, lmode_prev_q, rise;
  logic [2:0] bitcnt_q;
  logic [7:0] shift_q;
  logic       byte_done_q, byte_is_data_q;

  assign lclk  = p_ratio;
  assign lmode = p_deemph[1];
  assign ldata = p_adc[1];
  assign rise  = serial && lclk && !lclk_prev_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lclk_prev_q    <= 1'b1;
      lmode_prev_q   <= 1'b0;
      bitcnt_q       <= 3'h0;
      shift_q        <= 8'h00;
      byte_done_q    <= 1'b0;
      byte_is_data_q <= 1'b0;
    end else if (ce) begin
      lclk_prev_q  <= lclk;
      lmode_prev_q <= lmode;
      byte_done_q  <= 1'b0;
      // a mode edge starts a fresh byte; partial bytes drop
      if (!serial || lmode != lmode_prev_q) begin
        bitcnt_q <= 3'h0;
      end else if (rise) begin
        shift_q  <= {ldata, shift_q[7:1]};
        bitcnt_q <= bitcnt_q + 3'h1;
        if (bitcnt_q == 3'h7) begin
          byte_done_q    <= 1'b1;
          byte_is_data_q <= lmode;
        end
      end
    end
  end

  // ********************
  // address phase
  // ********************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selected_q  <= 1'b0;
      xfer_type_q <= `CCP_TYPE_DATA;
    end else if (ce) begin
      if (byte_done_q && !byte_is_data_q) begin
        // match or deselect, then hold until next address
        selected_q  <= (shift_q[`CCP_ADDR_MSB:`CCP_ADDR_LSB] == DEV_ADDR);
        xfer_type_q <= shift_q[1:0];
      end
    end
  end

  // ********************
  // data phase commits
  // ********************
  logic       wr_status, wr_data;
  logic [1:0] reg_sel;

  assign reg_sel   = shift_q[`CCP_SEL_MSB:`CCP_SEL_LSB];
  assign wr_status = byte_done_q && byte_is_data_q && selected_q
                     && xfer_type_q == `CCP_TYPE_STATUS;
  assign wr_data   = byte_done_q && byte_is_data_q && selected_q
                     && xfer_type_q == `CCP_TYPE_DATA;

  // ********************
  // static pin decode
  // ********************
  logic [2:0] st_fmt;

  always_comb begin
    case ({p_fmt_a, p_fmt_b})
      2'b00:   st_fmt = `CCP_IF_MSB;
      2'b01:   st_fmt = `CCP_IF_I2S;
      2'b10:   st_fmt = `CCP_IF_LSB20_MSBOUT;
      default: st_fmt = `CCP_IF_LSB16_MSBOUT;
    endcase
  end

  // ********************
  // status group fields
  // ********************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_ratio_field_q <= `CCP_RST_SC;
      input_format_q      <= `CCP_RST_IF;
      dc_filter_q         <= 1'b0;
    end else if (ce) begin
      if (static_m) begin
        clock_ratio_field_q <= p_ratio ? `CCP_SC_384 : `CCP_SC_256;
        input_format_q      <= st_fmt;
        dc_filter_q         <= 1'b0;
      end else if (wr_status && reg_sel == 2'h0) begin
        clock_ratio_field_q <= shift_q[5:4];
        input_format_q      <= shift_q[3:1];
        dc_filter_q         <= shift_q[0];
      end
    end
  end

  // ********************
  // data group fields
  // ********************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      volume_field_q        <= `CCP_RST_VOLUME;
      bass_boost_q          <= 4'h0;
      treble_q              <= 2'h0;
      deemphasis_q          <= `CCP_DE_NONE;
      mute_q                <= 1'b0;
      filter_mode_q         <= 2'h0;
      power_control_field_q <= `CCP_RST_POWER;
    end else if (ce) begin
      if (static_m) begin
        // mid level gives de-emphasis, any high code mutes
        deemphasis_q <= (p_deemph == `CCP_LVL_MID) ? `CCP_DE_44K1 : `CCP_DE_NONE;
        mute_q       <= p_deemph[1];
      end else if (wr_data) begin
        case (reg_sel)
          2'h0: volume_field_q <= shift_q[5:0];
          2'h1: begin
            bass_boost_q <= shift_q[5:2];
            treble_q     <= shift_q[1:0];
          end
          2'h2: begin
            deemphasis_q  <= shift_q[4:3];
            mute_q        <= shift_q[2];
            filter_mode_q <= shift_q[1:0];
          end
          default: power_control_field_q <= shift_q[1:0];
        endcase
      end
    end
  end

  // ********************
  // adc gain and power-down
  // ********************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_powerdown_q <= 1'b0;
      adc_gain_6db_q  <= 1'b0;
    end else if (ce) begin
      if (static_m) begin
        adc_powerdown_q <= (p_adc == `CCP_LVL_LOW);
        adc_gain_6db_q  <= (p_adc == `CCP_LVL_MID);
      end else if (serial) begin
        adc_powerdown_q <= 1'b0;
        adc_gain_6db_q  <= p_fmt_b;
      end
    end
  end

  // ********************
  // overload detector
  // ********************
  localparam logic signed [SW-1:0] THR_POS = SW'(THRESH);
  localparam logic signed [SW-1:0] THR_NEG = SW'(-THRESH);
  localparam logic [9:0]           HOLD_N  = 10'(HOLD - 1);

  logic       over;
  logic [9:0] hold_q;

  assign over = sample_valid &&
                ($signed(left_sample) > THR_POS || $signed(left_sample) < THR_NEG ||
                 $signed(right_sample) > THR_POS || $signed(right_sample) < THR_NEG);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overload_q <= 1'b0;
      hold_q     <= 10'h000;
    end else if (ce) begin
      if (!serial) begin
        overload_q <= 1'b0;
        hold_q     <= 10'h000;
      end else if (over) begin
        overload_q <= 1'b1;
        hold_q     <= HOLD_N;
      end else if (sample_valid && overload_q) begin
        // counts whole sample periods, so the flag never ends early
        if (hold_q == 10'h000) begin
          overload_q <= 1'b0;
        end else begin
          hold_q <= hold_q - 10'h001;
        end
      end
    end
  end

  // ********************
  // pin drive
  // ********************
  // only the overload pin is ever driven; link data is input only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins.ovl_out  <= 1'b0;
      pins.ovl_oe_n <= 1'b1;
    end else if (ce) begin
      pins.ovl_out  <= overload_q;
      pins.ovl_oe_n <= !serial;
    end
  end

endmodule // ccp_device

`default_nettype wire

// File: rtl/ccp_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccp_defs.svh"

module ccp_host import ccp_pkg::*; #(
  parameter int HALF_CYC = (`CCP_LINK_HALF_NS + `CCP_CLK_PERIOD_NS - 1) / `CCP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [8:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [8:0] rdata_q,
  // pins
  ccp_if.host             pins
);

  // ********************
  // configuration register
  // ********************
  logic [`CCP_PINS_WIDTH-1:0] cfg_q;
  logic                       ovl_syn;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= `CCP_RST_PINS;
    end else if (ce && wr && addr == `CCP_REG_PINS) begin
      cfg_q <= wdata;
    end
  end

  ccp_sync #(.WIDTH(1)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       (pins.format_pin_a_or_overload_out),
    .q       (ovl_syn)
  );

  // ********************
  // link sequencer
  // ********************
  localparam logic [15:0] HALF_N = 16'(HALF_CYC - 1);

  ccp_hstate_type state_q;
  logic [15:0]    cnt_q;
  logic [2:0]     bit_q;
  logic [7:0]     byte_q;
  logic           lclk_q, lmode_q, ldata_q, tick, start;

  assign tick  = (cnt_q == 16'h0000);
  assign start = wr && (addr == `CCP_REG_SEND_ADDR || addr == `CCP_REG_SEND_DATA);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= CCP_H_IDLE;
      cnt_q   <= 16'h0000;
      bit_q   <= 3'h0;
      byte_q  <= 8'h00;
      lclk_q  <= 1'b1;
      lmode_q <= 1'b0;
      ldata_q <= 1'b0;
    end else if (ce) begin
      if (!tick) begin
        cnt_q <= cnt_q - 16'h0001;
      end
      case (state_q)
        CCP_H_IDLE: begin
          // sends while busy are dropped
          if (start) begin
            byte_q  <= wdata[7:0];
            lmode_q <= (addr == `CCP_REG_SEND_DATA);
            bit_q   <= 3'h0;
            cnt_q   <= HALF_N;
            state_q <= CCP_H_SETUP;
          end
        end
        CCP_H_SETUP: begin
          if (tick) begin
            lclk_q  <= 1'b0;
            ldata_q <= byte_q[0];
            cnt_q   <= HALF_N;
            state_q <= CCP_H_LOW;
          end
        end
        CCP_H_LOW: begin
          if (tick) begin
            lclk_q  <= 1'b1;
            cnt_q   <= HALF_N;
            state_q <= CCP_H_HIGH;
          end
        end
        CCP_H_HIGH: begin
          // half period from the divider keeps the rate in bounds
          if (tick) begin
            cnt_q <= HALF_N;
            if (bit_q == 3'h7) begin
              state_q <= CCP_H_HOLD;
            end else begin
              lclk_q  <= 1'b0;
              ldata_q <= byte_q[3'(bit_q + 3'h1)];
              bit_q   <= bit_q + 3'h1;
              state_q <= CCP_H_LOW;
            end
          end
        end
        CCP_H_HOLD: begin
          if (tick) begin
            state_q <= CCP_H_IDLE;
          end
        end
        default: state_q <= CCP_H_IDLE;
      endcase
    end
  end

  // ********************
  // pin drive
  // ********************
  logic ser;
  assign ser = !cfg_q[`CCP_PINS_MSA] && !cfg_q[`CCP_PINS_MSB_B];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins.mode_select_a                 <= 1'b0;
      pins.mode_select_b                 <= 1'b0;
      pins.host_fmt_a                    <= 1'b0;
      pins.deemph_mute_pin_or_link_mode  <= `CCP_LVL_LOW;
      pins.clock_ratio_pin_or_link_clock <= 1'b1;
      pins.adc_level_pin_or_link_data    <= `CCP_LVL_LOW;
      pins.format_pin_b_or_gain_select   <= 1'b0;
    end else if (ce) begin
      pins.mode_select_a <= cfg_q[`CCP_PINS_MSA];
      pins.mode_select_b <= cfg_q[`CCP_PINS_MSB_B];
      pins.host_fmt_a    <= cfg_q[`CCP_PINS_FMT_A];
      pins.format_pin_b_or_gain_select <= cfg_q[`CCP_PINS_FMT_B];
      if (ser) begin
        // link data only ever flows outward
        pins.deemph_mute_pin_or_link_mode  <= {lmode_q, 1'b0};
        pins.clock_ratio_pin_or_link_clock <= lclk_q;
        pins.adc_level_pin_or_link_data    <= {ldata_q, 1'b0};
      end else begin
        pins.deemph_mute_pin_or_link_mode  <= cfg_q[`CCP_PINS_DEEMPH_LSB +: 2];
        pins.clock_ratio_pin_or_link_clock <= cfg_q[`CCP_PINS_RATIO];
        pins.adc_level_pin_or_link_data    <= cfg_q[`CCP_PINS_ADC_LSB +: 2];
      end
    end
  end

  // ********************
  // read port
  // ********************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 9'h000;
    end else if (ce) begin
      rdata_q <= 9'h000;
      if (rd && addr == `CCP_REG_PINS) begin
        rdata_q <= cfg_q;
      end else if (rd && addr == `CCP_REG_STATUS) begin
        rdata_q[`CCP_STAT_BUSY] <= (state_q != CCP_H_IDLE);
        rdata_q[`CCP_STAT_OVL]  <= ovl_syn;
      end
    end
  end

endmodule // ccp_host

`default_nettype wire

// File: tb/ccp_link_props.sv
`timescale 1ns/10ps
`default_nettype none

module ccp_link_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // shared pins
  input wire logic       mode_select_a,
  input wire logic       mode_select_b,
  input wire logic       ovl_oe_n,
  input wire logic       format_pin_a_or_overload_out,
  input wire logic [1:0] deemph_mute_pin_or_link_mode,
  input wire logic       clock_ratio_pin_or_link_clock,
  input wire logic [1:0] adc_level_pin_or_link_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       ser, sta, lc, lm, ovl;
  logic [3:0] rises_q;
  assign ser = !mode_select_a && !mode_select_b;
  assign sta = mode_select_a && mode_select_b;
  assign lc  = clock_ratio_pin_or_link_clock;
  assign lm  = deemph_mute_pin_or_link_mode[1];
  assign ovl = format_pin_a_or_overload_out;
  // rises since last mode edge; mod 8 so long data runs still pass
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      rises_q <= 4'h0;
    else if (!ser || $changed(lm))
      rises_q <= 4'h0;
    else if ($rose(lc))
      rises_q <= rises_q + 4'h1;
  end
  a_static_undriven: assert property (sta [*6] |=> ovl_oe_n)
    else $error("overload pin driven in static mode");
  a_serial_drives: assert property (ser [*6] |=> !ovl_oe_n)
    else $error("overload pin not driven in serial mode");
  a_whole_bytes: assert property (ser && $changed(lm) |-> rises_q[2:0] == 3'h0)
    else $error("burst not a multiple of eight pulses");
  a_clock_low_time: assert property (ser && $fell(lc) |-> (!lc) [*7] ##[1:3] lc)
    else $error("link clock low phase wrong length");
  a_data_steady: assert property (ser && $rose(lc) |-> $stable(adc_level_pin_or_link_data[1]))
    else $error("link data moved at clock rise");
  a_mode_on_high: assert property (ser && $past(ser) && $changed(lm) |-> lc)
    else $error("link mode changed with clock low");
  a_mode_held_low: assert property (ser && $past(ser) && !lc |-> $stable(lm))
    else $error("link mode moved inside a burst");
  a_ovl_held: assert property (!ovl_oe_n && $past(!ovl_oe_n) && $rose(ovl) |=> ovl [*8])
    else $error("overload flag dropped early");
  c_address: cover property (ser && $fell(lm));
  c_data: cover property (ser && $rose(lm));
  c_overload: cover property (!ovl_oe_n && $rose(ovl));
endmodule  // ccp_link_props

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccp_defs.svh"

module tb_top import ccp_pkg::*; ;
  // ********************
  // signals
  // ********************
  localparam logic [5:0] DA = 6'h2a;  // arbitrary value
  localparam logic [7:0] DB [4] = '{8'h2d, 8'h6e, 8'h95, 8'hc3};
  localparam logic [2:0] FMT [4] = '{`CCP_IF_MSB, `CCP_IF_I2S, `CCP_IF_LSB20_MSBOUT,
                                     `CCP_IF_LSB16_MSBOUT};
  logic         clk, sys_rst, wr, rd, sample_valid, selected_q, dc_filter_q, mute_q;
  logic         adc_powerdown_q, adc_gain_6db_q, overload_q;
  logic [1:0]   xfer_type_q, clock_ratio_field_q, treble_q, deemphasis_q, filter_mode_q;
  logic [1:0]   power_control_field_q, lvl;
  logic [2:0]   input_format_q;
  logic [3:0]   bass_boost_q;
  logic [5:0]   volume_field_q;
  logic [7:0]   addr;
  logic [8:0]   wdata, rdata_q, seen;
  logic [19:0]  left_sample, right_sample;
  ccp_mode_type ctl_mode_q;
  int           miscompares, compares, i;

  ccp_if pins ();
  ccp_host #(.HALF_CYC(8)) i_ccp_host (.clk, .sys_rst, .ce(1'b1), .addr, .wdata, .wr, .rd,
    .rdata_q, .pins(pins));
  ccp_device #(.DEV_ADDR(DA), .HOLD(4)) i_ccp_device (.clk, .sys_rst, .ce(1'b1), .pins(pins),
    .sample_valid, .left_sample, .right_sample, .ctl_mode_q, .selected_q, .xfer_type_q,
    .clock_ratio_field_q, .input_format_q, .dc_filter_q, .volume_field_q, .bass_boost_q,
    .treble_q, .deemphasis_q, .mute_q, .filter_mode_q, .power_control_field_q,
    .adc_powerdown_q, .adc_gain_6db_q, .overload_q);
  ccp_link_props i_ccp_link_props (.clk, .sys_rst, .mode_select_a(pins.mode_select_a),
    .mode_select_b(pins.mode_select_b), .ovl_oe_n(pins.ovl_oe_n),
    .format_pin_a_or_overload_out(pins.format_pin_a_or_overload_out),
    .deemph_mute_pin_or_link_mode(pins.deemph_mute_pin_or_link_mode),
    .clock_ratio_pin_or_link_clock(pins.clock_ratio_pin_or_link_clock),
    .adc_level_pin_or_link_data(pins.adc_level_pin_or_link_data));

  // ********************
  // tasks
  // ********************
  task automatic check(input string what, input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [8:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    seen = rdata_q;
  endtask
  task automatic send(input logic [7:0] a, input logic [7:0] d);
    reg_wr(a, {1'b0, d});
    repeat (200) begin
      reg_rd(`CCP_REG_STATUS);
      if (seen[0] === 1'b0) break;
    end
    check("busy", seen[0], 1'b0);
    settle();
  endtask
  task automatic pins_set(input logic [8:0] d);
    reg_wr(`CCP_REG_PINS, d);
    settle();
  endtask
  task automatic samp(input logic [19:0] l, input logic [19:0] r);
    @(posedge clk);
    sample_valid <= 1'b1;
    left_sample <= l;
    right_sample <= r;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ********************
  // clock, watchdog, tests
  // ********************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, wr, rd, sample_valid} = 4'h8;
    {addr, wdata, left_sample, right_sample} = '0;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    check("mode", ctl_mode_q, CCP_SERIAL);
    check("oe_n", pins.ovl_oe_n, 1'b0);
    send(`CCP_REG_SEND_ADDR, {DA, `CCP_TYPE_STATUS});
    send(`CCP_REG_SEND_DATA, 8'h29);
    check("sel", {selected_q, xfer_type_q}, 3'h6);
    check("status", {clock_ratio_field_q, input_format_q, dc_filter_q}, 6'h29);
    send(`CCP_REG_SEND_ADDR, {DA, `CCP_TYPE_DATA});
    for (i = 0; i < 4; i++) send(`CCP_REG_SEND_DATA, DB[i]);
    check("vol", volume_field_q, 6'h2d);
    check("tone", {bass_boost_q, treble_q}, 6'h2e);
    check("deemph", {deemphasis_q, mute_q, filter_mode_q}, 5'h15);
    check("power", power_control_field_q, 2'h3);
    send(`CCP_REG_SEND_ADDR, {6'h15, `CCP_TYPE_DATA});
    send(`CCP_REG_SEND_DATA, 8'h01);
    check("sel", selected_q, 1'b0);
    send(`CCP_REG_SEND_ADDR, {DA, 2'h1});
    send(`CCP_REG_SEND_DATA, 8'h01);
    check("vol", volume_field_q, 6'h2d);
    send(`CCP_REG_SEND_ADDR, {DA, `CCP_TYPE_DATA});
    send(`CCP_REG_SEND_DATA, 8'h3f);
    check("vol", volume_field_q, 6'h3f);
    pins_set(9'h100);
    check("gain", adc_gain_6db_q, 1'b1);
    pins_set(9'h000);
    check("gain", adc_gain_6db_q, 1'b0);
    samp(20'h70000, 20'h6ff9a);
    check("ovl", {overload_q, pins.format_pin_a_or_overload_out}, 2'h3);
    reg_rd(`CCP_REG_STATUS);
    check("stat", seen, 9'h002);
    repeat (3) samp(20'h6ff9a, 20'h6ff9a);
    samp(20'h0, 20'h70000);
    repeat (3) samp(20'h6ff9a, 20'h0);
    check("ovl", overload_q, 1'b1);
    samp(20'h0, 20'h0);
    check("ovl", {overload_q, pins.format_pin_a_or_overload_out}, 2'h0);
    for (i = 0; i < 4; i++) begin
      lvl = (i == 0) ? `CCP_LVL_LOW : (i == 1) ? `CCP_LVL_MID : `CCP_LVL_HIGH;
      pins_set({i[0], lvl, i[0], lvl, i[1], 2'h3});
      check("mode", ctl_mode_q, CCP_STATIC);
      check("ratio", clock_ratio_field_q, i[0] ? `CCP_SC_384 : `CCP_SC_256);
      check("fmt", input_format_q, FMT[i]);
      check("mute", mute_q, i > 1);
      if (i < 2) check("de", deemphasis_q, i[0] ? `CCP_DE_44K1 : `CCP_DE_NONE);
      check("adc", {adc_powerdown_q, adc_gain_6db_q}, 2'h2 >> i);
    end
    pins_set(9'h001);
    check("mode", ctl_mode_q, CCP_TEST);
    tally_and_finish();
  end
endmodule  // tb_top

`default_nettype wire
